// [verilog/smie_top.sv]
// datapath for right shift, copy and indirect load, with wishbone slave
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module smie_top
	import smie_pkg::*;
(
	input wire logic clk_i, // core clock
	input wire logic rst_i, // synchronous reset
	input wire logic cyc_i, // wishbone cycle
	input wire logic stb_i, // wishbone strobe
	input wire logic we_i, // wishbone write
	input wire logic [7:0] adr_i, // wishbone byte address
	input wire logic [3:0] sel_i, // wishbone byte enables
	input wire logic [31:0] dat_i, // wishbone write data
	output logic [31:0] dat_o, // wishbone read data
	output logic ack_o, // wishbone acknowledge
	output logic busy_o, // high for the one execute cycle of an instruction
	output logic carry_o, // carry flag
	output logic zero_o // zero flag
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	smie_state_e state;
	smie_mem_if mem_port ();

	logic pend;
	logic bus_req;
	logic wr_ack;
	logic [31:0] cmd;
	logic [7:0] acc;
	logic [15:0] ptr0;
	logic [15:0] ptr1;
	logic [7:0] maddr;
	logic carry;
	logic zero;

	logic [1:0] cmd_op;
	logic cmd_dest;
	logic cmd_psel;
	logic cmd_rel;
	logic [1:0] cmd_mm;
	logic [5:0] cmd_off;
	logic [6:0] cmd_faddr;

	logic [15:0] sel_ptr;
	logic [15:0] off_ext;
	logic [15:0] ptr_inc;
	logic [15:0] ptr_dec;
	logic [15:0] ind_ea;
	logic [15:0] next_ptr;
	logic is_alias;
	logic alias_psel;
	logic [15:0] ea;
	logic [7:0] rd_val;
	logic [7:0] result;
	logic result_zero;
	logic exec_wr_file;
	logic exec_wr_acc;
	logic start;
	logic [31:0] rd_mux;
	logic [31:0] ptr0_wr;
	logic [31:0] ptr1_wr;

	// ----------------------------------------------------------------
	// byte-lane merge for register writes
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(
		input logic [31:0] cur,
		input logic [31:0] wr,
		input logic [3:0] sel
	);
		logic [31:0] mask;
		mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		merge = (cur & ~mask) | (wr & mask);
	endfunction : merge

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	assign bus_req = cyc_i && stb_i;
	assign wr_ack = bus_req && we_i && ack_o;

	// one pending cycle lets the store's registered read settle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend <= 1'b0;
		end else if (ack_o || !bus_req) begin
			pend <= 1'b0;
		end else if (!pend) begin
			pend <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= pend && bus_req && !ack_o;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (adr_i)
			ADDR_CMD: rd_mux = cmd;
			ADDR_STATUS: begin
				rd_mux[ST_BUSY_BIT] = (state != ST_IDLE);
				rd_mux[ST_CARRY_BIT] = carry;
				rd_mux[ST_ZERO_BIT] = zero;
			end
			ADDR_ACC: rd_mux[7:0] = acc;
			ADDR_PTR0: rd_mux[15:0] = ptr0;
			ADDR_PTR1: rd_mux[15:0] = ptr1;
			ADDR_MADDR: rd_mux[7:0] = maddr;
			ADDR_MDATA: rd_mux[7:0] = mem_port.rdata;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (pend && bus_req && !we_i) begin
			dat_o <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// command register and field split
	// ----------------------------------------------------------------
	assign start = wr_ack && (adr_i == ADDR_CMD) && (state == ST_IDLE);

	// a command written while busy is dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd <= CMD_RST;
		end else if (start) begin
			cmd <= merge(cmd, dat_i, sel_i);
		end
	end

	assign cmd_op = cmd[CMD_OP_LSB +: 2];
	assign cmd_dest = cmd[CMD_DEST_BIT];
	assign cmd_psel = cmd[CMD_PSEL_BIT];
	assign cmd_rel = cmd[CMD_REL_BIT];
	assign cmd_mm = cmd[CMD_MM_LSB +: 2];
	assign cmd_off = cmd[CMD_OFF_LSB +: 6];
	assign cmd_faddr = cmd[CMD_FADDR_LSB +: 7];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			maddr <= 8'h00;
		end else if (wr_ack && (adr_i == ADDR_MADDR) && sel_i[0]) begin
			maddr <= dat_i[7:0];
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start && (merge(cmd, dat_i, sel_i) != CMD_RST) &&
						(merge(cmd, dat_i, sel_i) & 32'h0000_0003) != 32'h0) begin
						state <= ST_FETCH;
					end
				end
				ST_FETCH: state <= ST_EXEC;
				ST_EXEC: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// address generation
	// ----------------------------------------------------------------
	assign sel_ptr = cmd_psel ? ptr1 : ptr0;
	assign off_ext = {{10{cmd_off[5]}}, cmd_off};
	assign ptr_inc = sel_ptr + 16'h0001;
	assign ptr_dec = sel_ptr - 16'h0001;

	always_comb begin
		ind_ea = sel_ptr;
		next_ptr = sel_ptr;
		if (cmd_rel) begin
			ind_ea = sel_ptr + off_ext;
		end else begin
			case (cmd_mm)
				MM_PRE_INC: ind_ea = ptr_inc;
				MM_PRE_DEC: ind_ea = ptr_dec;
				MM_POST_INC: ind_ea = sel_ptr;
				MM_POST_DEC: ind_ea = sel_ptr;
				default: ind_ea = sel_ptr;
			endcase
			next_ptr = cmd_mm[0] ? ptr_dec : ptr_inc;
		end
	end

	// alias file addresses hold no storage of their own
	assign is_alias = (cmd_faddr == ALIAS0_FADDR) ||
		(cmd_faddr == ALIAS1_FADDR);
	assign alias_psel = (cmd_faddr == ALIAS1_FADDR);

	always_comb begin
		if (cmd_op == OP_INDIRECT) begin
			ea = ind_ea;
		end else if (is_alias) begin
			ea = alias_psel ? ptr1 : ptr0;
		end else begin
			ea = {9'h000, cmd_faddr};
		end
	end

	// ----------------------------------------------------------------
	// result path
	// ----------------------------------------------------------------
	assign rd_val = mem_port.rdata;

	always_comb begin
		case (cmd_op)
			OP_SHIFT_RIGHT: result = {1'b0, rd_val[7:1]};
			OP_COPY: result = rd_val;
			OP_INDIRECT: result = rd_val;
			default: result = rd_val;
		endcase
	end

	assign result_zero = (result == 8'h00);
	assign exec_wr_file = (state == ST_EXEC) && cmd_dest &&
		(cmd_op == OP_SHIFT_RIGHT || cmd_op == OP_COPY);
	assign exec_wr_acc = (state == ST_EXEC) && (cmd_op != OP_NONE) &&
		((cmd_op == OP_INDIRECT) || !cmd_dest);

	// ----------------------------------------------------------------
	// store port: sequencer owns it while busy
	// ----------------------------------------------------------------
	always_comb begin
		if (state != ST_IDLE) begin
			mem_port.addr = ea[7:0];
			mem_port.wdata = result;
			mem_port.we = exec_wr_file;
		end else begin
			mem_port.addr = maddr;
			mem_port.wdata = dat_i[7:0];
			mem_port.we = wr_ack && (adr_i == ADDR_MDATA) && sel_i[0];
		end
	end

	smie_mem i_smie_mem (
		.clk_i(clk_i),
		.port_i(mem_port.store)
	);

	// ----------------------------------------------------------------
	// accumulator
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= ACC_RST;
		end else if (exec_wr_acc) begin
			acc <= result;
		end else if (wr_ack && (adr_i == ADDR_ACC) && sel_i[0]) begin
			acc <= dat_i[7:0];
		end
	end

	// ----------------------------------------------------------------
	// pointers
	// ----------------------------------------------------------------
	// software write, merged per byte lane
	assign ptr0_wr = merge({16'h0000, ptr0}, dat_i, sel_i);
	assign ptr1_wr = merge({16'h0000, ptr1}, dat_i, sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr0 <= PTR_RST;
		end else if ((state == ST_EXEC) && (cmd_op == OP_INDIRECT) &&
			!cmd_rel && !cmd_psel) begin
			ptr0 <= next_ptr;
		end else if (wr_ack && (adr_i == ADDR_PTR0)) begin
			ptr0 <= ptr0_wr[15:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr1 <= PTR_RST;
		end else if ((state == ST_EXEC) && (cmd_op == OP_INDIRECT) &&
			!cmd_rel && cmd_psel) begin
			ptr1 <= next_ptr;
		end else if (wr_ack && (adr_i == ADDR_PTR1)) begin
			ptr1 <= ptr1_wr[15:0];
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	// carry moves only on the shift or a status write; pointer moves never touch carry, but the indirect load sets zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carry <= 1'b0;
		end else if ((state == ST_EXEC) && (cmd_op == OP_SHIFT_RIGHT)) begin
			carry <= rd_val[0];
		end else if (wr_ack && (adr_i == ADDR_STATUS) && sel_i[0]) begin
			carry <= dat_i[ST_CARRY_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zero <= 1'b0;
		end else if ((state == ST_EXEC) && (cmd_op != OP_NONE)) begin
			zero <= result_zero;
		end else if (wr_ack && (adr_i == ADDR_STATUS) && sel_i[0]) begin
			zero <= dat_i[ST_ZERO_BIT];
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= (state == ST_FETCH);
		end
	end

	assign carry_o = carry;
	assign zero_o = zero;

endmodule : smie_top
`default_nettype wire

// [shared/smie_pkg.sv]
// constants and types of the shift, copy and indirect-load datapath
package smie_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int PTR_W = 16;
	localparam int FADDR_W = 7;
	localparam int MEM_AW = 8;
	localparam int MEM_DEPTH = 256;
	localparam int WB_AW = 8;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ACC = 8'h08;
	localparam logic [7:0] ADDR_PTR0 = 8'h0C;
	localparam logic [7:0] ADDR_PTR1 = 8'h10;
	localparam logic [7:0] ADDR_MADDR = 8'h14;
	localparam logic [7:0] ADDR_MDATA = 8'h18;

	// ----------------------------------------------------------------
	// command word fields
	// ----------------------------------------------------------------
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_DEST_BIT = 2;
	localparam int CMD_PSEL_BIT = 3;
	localparam int CMD_REL_BIT = 4;
	localparam int CMD_MM_LSB = 5;
	localparam int CMD_OFF_LSB = 7;
	localparam int CMD_FADDR_LSB = 16;

	// status word fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_CARRY_BIT = 1;
	localparam int ST_ZERO_BIT = 2;

	// ----------------------------------------------------------------
	// operations, update selector, alias addresses
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_NONE = 2'h0;
	localparam logic [1:0] OP_SHIFT_RIGHT = 2'h1;
	localparam logic [1:0] OP_COPY = 2'h2;
	localparam logic [1:0] OP_INDIRECT = 2'h3;
	localparam logic [1:0] MM_PRE_INC = 2'h0;
	localparam logic [1:0] MM_PRE_DEC = 2'h1;
	localparam logic [1:0] MM_POST_INC = 2'h2;
	localparam logic [1:0] MM_POST_DEC = 2'h3;
	localparam logic [6:0] ALIAS0_FADDR = 7'h00;
	localparam logic [6:0] ALIAS1_FADDR = 7'h01;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [31:0] CMD_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_EXEC = 3'b100
	} smie_state_e;

endpackage : smie_pkg

// [shared/smie_mem_if.sv]
// memory port carried between the datapath and its data store
`timescale 1ns/1ps
`default_nettype none
interface smie_mem_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic we;
	logic [7:0] rdata;
	modport ctrl (output addr, output wdata, output we, input rdata);
	modport store (input addr, input wdata, input we, output rdata);
endinterface : smie_mem_if
`default_nettype wire

// [verilog/smie_mem.sv]
// data store with registered read
`timescale 1ns/1ps
`default_nettype none
module smie_mem
	import smie_pkg::*;
(
	input wire logic clk_i, // core clock
	smie_mem_if.store port_i // read and write port
);

	logic [7:0] cells [MEM_DEPTH];

	// ----------------------------------------------------------------
	// write and registered read
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (port_i.we) begin
			cells[port_i.addr] <= port_i.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		port_i.rdata <= cells[port_i.addr];
	end

endmodule : smie_mem
`default_nettype wire

// [tb/smie_properties.sv]
// port assertions for the shift, copy and indirect-load datapath
`timescale 1ns/1ps
`default_nettype none
module smie_properties
	import smie_pkg::*;
(
	input wire logic clk_i, // core clock
	input wire logic rst_i, // synchronous reset
	input wire logic cyc_i, // bus cycle
	input wire logic stb_i, // bus strobe
	input wire logic we_i, // bus write
	input wire logic [7:0] adr_i, // bus address
	input wire logic [3:0] sel_i, // byte enables
	input wire logic [31:0] dat_i, // write data
	input wire logic [31:0] dat_o, // read data
	input wire logic ack_o, // acknowledge
	input wire logic busy_o, // execute cycle
	input wire logic carry_o, // carry flag
	input wire logic zero_o // zero flag
);
	// ----
	// helper logic
	// ----
	logic [1:0] op;
	logic st_wr;
	logic cmd_wr;
	assign st_wr = ack_o && we_i && adr_i == ADDR_STATUS && sel_i[0];
	assign cmd_wr = ack_o && we_i && adr_i == ADDR_CMD && sel_i[0];
	// last accepted operation
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op <= OP_NONE;
		end else if (cmd_wr && !busy_o) begin
			op <= dat_i[1:0];
		end
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----
	// assertions
	// ----
	reset_clear_a: assert property ($fell(rst_i) |-> !ack_o && !busy_o
		&& !carry_o && !zero_o && dat_o == 32'h0)
		else $error("outputs not cleared by reset");
	ack_latency_a: assert property ($rose(cyc_i && stb_i)
		|-> !ack_o ##1 !ack_o ##1 ack_o)
		else $error("ack not on third edge");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i, 2))
		else $error("ack without request");
	busy_pulse_a: assert property (busy_o |=> !busy_o)
		else $error("execute longer than one cycle");
	cmd_start_a: assert property (cmd_wr && !busy_o
		|=> !busy_o ##1 (busy_o == (op != OP_NONE)))
		else $error("instruction start misplaced");
	zero_cause_a: assert property ($changed(zero_o)
		|-> $past(busy_o) || $past(st_wr))
		else $error("zero changed without cause");
	carry_cause_a: assert property ($changed(carry_o)
		|-> $past(st_wr) || ($past(busy_o) && op == OP_SHIFT_RIGHT))
		else $error("carry changed without shift");
endmodule : smie_properties
`default_nettype wire

// [tb/smie_top_tb_top.sv]
// self-checking bench for the datapath top
`timescale 1ns/1ps
`default_nettype none
module smie_top_tb_top
	import smie_pkg::*;
;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, busy_o, carry_o, zero_o;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, q;
	logic [7:0] dv [4];
	int n_errors, tests_run;
	smie_top i_smie_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .busy_o(busy_o),
		.carry_o(carry_o), .zero_o(zero_o));
	// ----
	// tasks
	// ----
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// one classic cycle, read data left in q
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do @(posedge clk_i); while (ack_o !== 1'h1);
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i <= 1'h0;
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		wb(1'h0, a, 32'h0);
	endtask : rd
	task automatic mw(input logic [7:0] a, input logic [7:0] d);
		wr(ADDR_MADDR, {24'h0, a});
		wr(ADDR_MDATA, {24'h0, d});
	endtask : mw
	task automatic mr(input logic [7:0] a);
		wr(ADDR_MADDR, {24'h0, a});
		rd(ADDR_MDATA);
	endtask : mr
	task automatic ex(input logic [31:0] c);
		wr(ADDR_CMD, c);
		for (int i = 0; i < 8; i++) begin
			rd(ADDR_STATUS);
			if (q[ST_BUSY_BIT] === 1'h0) break;
		end
		chk({15'h0000, q[ST_BUSY_BIT]}, 16'h0000);
	endtask : ex
	// flags through status and ports
	task automatic fl(input logic c, input logic z);
		rd(ADDR_STATUS);
		chk({q[2:0], zero_o, carry_o}, {z, c, 1'h0, z, c});
	endtask : fl
	function automatic logic [31:0] mk(input logic [1:0] op,
		input logic d, input logic p, input logic r, input logic [1:0] m,
		input logic [5:0] off, input logic [6:0] f);
		return {9'h0, f, 3'h0, off, m, r, p, d, op};
	endfunction : mk
	task automatic conclude;
		if (n_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude
	// ----
	// clock, watchdog, tests
	// ----
	initial begin
		clk_i = 1'h0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		conclude();
	end
	initial begin
		{rst_i, cyc_i, stb_i, we_i} = 4'h8;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0;
		n_errors = 0;
		tests_run = 0;
		dv = '{8'h33, 8'h11, 8'h22, 8'h22};
		repeat (5) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(ADDR_PTR0);
		chk(q[15:0], 16'h0000);
		fl(1'h0, 1'h0);
		wr(8'h1C, 32'hFFFF_FFFF);
		rd(8'h1C);
		chk(q[15:0], 16'h0000);
		// right shift to accumulator, then in place
		mw(8'h20, 8'hA5);
		mw(8'h21, 8'h01);
		ex(mk(OP_SHIFT_RIGHT, 1'h0, 1'h0, 1'h0, 2'h0, 6'h0, 7'h20));
		rd(ADDR_ACC);
		chk(q[7:0], 8'h52);
		fl(1'h1, 1'h0);
		mr(8'h20);
		chk(q[7:0], 8'hA5);
		ex(mk(OP_SHIFT_RIGHT, 1'h1, 1'h0, 1'h0, 2'h0, 6'h0, 7'h21));
		mr(8'h21);
		chk(q[7:0], 8'h00);
		fl(1'h1, 1'h1);
		// copy both ways
		mw(8'h22, 8'h00);
		ex(mk(OP_COPY, 1'h0, 1'h0, 1'h0, 2'h0, 6'h0, 7'h22));
		rd(ADDR_ACC);
		chk(q[7:0], 8'h00);
		fl(1'h1, 1'h1);
		ex(mk(OP_COPY, 1'h1, 1'h0, 1'h0, 2'h0, 6'h0, 7'h20));
		mr(8'h20);
		chk(q[7:0], 8'hA5);
		fl(1'h1, 1'h0);
		// every pointer update mode
		mw(8'h3F, 8'h11);
		mw(8'h40, 8'h22);
		mw(8'h41, 8'h33);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_PTR0, 32'h0040);
			ex(mk(OP_INDIRECT, 1'h0, 1'h0, 1'h0, 2'(i), 6'h0, 7'h0));
			rd(ADDR_ACC);
			chk(q[7:0], dv[i]);
			rd(ADDR_PTR0);
			chk(q[15:0], i[0] ? 16'h003F : 16'h0041);
			fl(1'h1, 1'h0);
		end
		// wrap at both ends
		mw(8'hFF, 8'h00);
		wr(ADDR_PTR1, 32'hFFFF);
		ex(mk(OP_INDIRECT, 1'h0, 1'h1, 1'h0, MM_POST_INC, 6'h0, 7'h0));
		rd(ADDR_PTR1);
		chk(q[15:0], 16'h0000);
		fl(1'h1, 1'h1);
		mw(8'hFF, 8'h7E);
		ex(mk(OP_INDIRECT, 1'h0, 1'h1, 1'h0, MM_PRE_DEC, 6'h0, 7'h0));
		rd(ADDR_ACC);
		chk(q[7:0], 8'h7E);
		rd(ADDR_PTR1);
		chk(q[15:0], 16'hFFFF);
		// relative offset at both limits
		mw(8'h30, 8'h5A);
		mw(8'h6F, 8'hC3);
		wr(ADDR_PTR1, 32'h0050);
		ex(mk(OP_INDIRECT, 1'h0, 1'h1, 1'h1, 2'h0, 6'h20, 7'h0));
		rd(ADDR_ACC);
		chk(q[7:0], 8'h5A);
		ex(mk(OP_INDIRECT, 1'h0, 1'h1, 1'h1, 2'h3, 6'h1F, 7'h0));
		rd(ADDR_ACC);
		chk(q[7:0], 8'hC3);
		rd(ADDR_PTR1);
		chk(q[15:0], 16'h0050);
		// alias redirect
		wr(ADDR_PTR0, 32'h0020);
		ex(mk(OP_COPY, 1'h0, 1'h0, 1'h0, 2'h0, 6'h0, ALIAS0_FADDR));
		rd(ADDR_ACC);
		chk(q[7:0], 8'hA5);
		rd(ADDR_PTR0);
		chk(q[15:0], 16'h0020);
		// reset in mid-run clears registers and flags
		@(posedge clk_i);
		rst_i <= 1'h1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(ADDR_ACC);
		chk(q[7:0], 8'h00);
		rd(ADDR_PTR1);
		chk(q[15:0], 16'h0000);
		fl(1'h0, 1'h0);
		// shift in place through an alias lands at its pointer
		mw(8'h01, 8'h99);
		wr(ADDR_PTR1, 32'h006F);
		ex(mk(OP_SHIFT_RIGHT, 1'h1, 1'h0, 1'h0, 2'h0, 6'h0, ALIAS1_FADDR));
		mr(8'h6F);
		chk(q[7:0], 8'h61);
		mr(8'h01);
		chk(q[7:0], 8'h99);
		fl(1'h1, 1'h0);
		conclude();
	end
endmodule : smie_top_tb_top
bind smie_top smie_properties i_smie_properties (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .busy_o(busy_o), .carry_o(carry_o), .zero_o(zero_o));
`default_nettype wire
